// ### logic/csb_cfg.svh
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// widths
`define CSB_PC_W 16
`define CSB_OFS_W 7
`define CSB_DATA_W 8
`define CSB_BIT_W 3

// status flag positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5

// reset values
`define CSB_PC_RST 16'h0000
`define CSB_FLAGS_RST 8'h00

// program counter steps
`define CSB_PC_STEP 16'h0001
`define CSB_SKIP_ONE 16'h0002
`define CSB_SKIP_TWO 16'h0003

// wait cycles after the first cycle
`define CSB_WAIT_BRANCH 2'h1
`define CSB_WAIT_SKIP_ONE 2'h1
`define CSB_WAIT_SKIP_TWO 2'h2

`endif

// ### logic/csb_pkg.sv
package csb_pkg;

    typedef enum logic [3:0] {
        OP_OTHER = 4'h0,
        OP_COMPARE_SKIP_EQUAL = 4'h1,
        OP_COMPARE_IMMEDIATE = 4'h2,
        OP_SKIP_REG_BIT_CLEAR = 4'h3,
        OP_SKIP_IO_BIT_SET = 4'h4,
        OP_SKIP_IO_BIT_CLEAR = 4'h5,
        OP_BRANCH_FLAG_SET = 4'h6,
        OP_BRANCH_FLAG_CLEAR = 4'h7,
        OP_BRANCH_CARRY_CLEAR = 4'h8,
        OP_BRANCH_SIGNED_GE = 4'h9,
        OP_BRANCH_SIGNED_LT = 4'ha
    } csb_op_t;

    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_WAIT = 2'b10
    } csb_state_t;

    typedef struct packed {
        logic z;
        logic n;
        logic v;
        logic c;
        logic h;
    } csb_cmp_flags_t;

endpackage

// ### logic/csb_cmp_if.sv
`timescale 1ns/10ps
`include "csb_cfg.svh"

interface csb_cmp_if;
    logic [`CSB_DATA_W-1:0] lhs;
    logic [`CSB_DATA_W-1:0] rhs;
    csb_pkg::csb_cmp_flags_t res;

    modport requester (output lhs, output rhs, input res);
    modport unit (input lhs, input rhs, output res);
endinterface

// ### logic/csb_cmp_unit.sv
`timescale 1ns/10ps
`include "csb_cfg.svh"

module csb_cmp_unit (
    // operands and flags
    csb_cmp_if.unit cmp
);
    logic [`CSB_DATA_W-1:0] diff;
    logic a7;
    logic b7;
    logic r7;
    logic a3;
    logic b3;
    logic r3;

    // subtract only, the difference is never stored
    always_comb begin
        diff = cmp.lhs - cmp.rhs;
        a7 = cmp.lhs[`CSB_DATA_W-1];
        b7 = cmp.rhs[`CSB_DATA_W-1];
        r7 = diff[`CSB_DATA_W-1];
        a3 = cmp.lhs[3];
        b3 = cmp.rhs[3];
        r3 = diff[3];
        cmp.res.z = (diff == '0);
        cmp.res.n = r7;
        cmp.res.v = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
        cmp.res.c = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);
        cmp.res.h = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
    end
endmodule // csb_cmp_unit

// ### logic/csb_unit.sv
`timescale 1ns/10ps
`include "csb_cfg.svh"

module csb_unit (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // decoded instruction
    input wire logic instr_valid_i,
    input wire csb_pkg::csb_op_t op_i,
    input wire logic [`CSB_DATA_W-1:0] reg_d_i,
    input wire logic [`CSB_DATA_W-1:0] reg_r_i,
    input wire logic [`CSB_DATA_W-1:0] imm_i,
    input wire logic [`CSB_BIT_W-1:0] bit_sel_i,
    input wire logic [`CSB_DATA_W-1:0] io_val_i,
    input wire logic [`CSB_OFS_W-1:0] offset_i,
    input wire logic next_two_word_i,
    // flag write from other units
    input wire logic flag_wr_i,
    input wire logic [`CSB_DATA_W-1:0] flag_data_i,
    // status
    output logic ready_o,
    output logic done_o,
    output logic [`CSB_PC_W-1:0] pc_o,
    output logic [`CSB_DATA_W-1:0] flags_o
);
    csb_pkg::csb_state_t state;
    logic [1:0] wait_cnt;
    logic [`CSB_PC_W-1:0] pc_target;
    logic accept;
    logic next_take;
    logic next_skip;
    logic is_branch;
    logic sel_flag;
    logic signed_lt;
    logic [1:0] next_wait;
    logic [`CSB_PC_W-1:0] next_pc;
    logic [`CSB_PC_W-1:0] br_target;

    csb_cmp_if cmp_bus ();

    csb_cmp_unit u_cmp (
        .cmp(cmp_bus)
    );

    assign cmp_bus.lhs = reg_d_i;
    assign cmp_bus.rhs = imm_i;
    assign accept = instr_valid_i && ready_o;

    // decide skip or branch at the first cycle
    always_comb begin
        sel_flag = flags_o[bit_sel_i];
        signed_lt = flags_o[`CSB_FLAG_N] ^ flags_o[`CSB_FLAG_V];
        br_target = pc_o + {{(`CSB_PC_W-`CSB_OFS_W){offset_i[`CSB_OFS_W-1]}}, offset_i}
            + `CSB_PC_STEP;
        next_take = 1'b0;
        next_skip = 1'b0;
        is_branch = 1'b0;
        case (op_i)
            csb_pkg::OP_COMPARE_SKIP_EQUAL: next_skip = (reg_d_i == reg_r_i);
            csb_pkg::OP_SKIP_REG_BIT_CLEAR: next_skip = ~reg_r_i[bit_sel_i];
            csb_pkg::OP_SKIP_IO_BIT_SET: next_skip = io_val_i[bit_sel_i];
            csb_pkg::OP_SKIP_IO_BIT_CLEAR: next_skip = ~io_val_i[bit_sel_i];
            csb_pkg::OP_BRANCH_FLAG_SET: begin
                is_branch = 1'b1;
                next_take = sel_flag;
            end
            csb_pkg::OP_BRANCH_FLAG_CLEAR: begin
                is_branch = 1'b1;
                next_take = ~sel_flag;
            end
            csb_pkg::OP_BRANCH_CARRY_CLEAR: begin
                is_branch = 1'b1;
                next_take = ~flags_o[`CSB_FLAG_C];
            end
            csb_pkg::OP_BRANCH_SIGNED_GE: begin
                is_branch = 1'b1;
                next_take = ~signed_lt;
            end
            csb_pkg::OP_BRANCH_SIGNED_LT: begin
                is_branch = 1'b1;
                next_take = signed_lt;
            end
            default: begin
                next_take = 1'b0;
                next_skip = 1'b0;
            end
        endcase
        // a skip steps over one or two words, one extra cycle each
        if (next_skip) begin
            next_pc = next_two_word_i ? pc_o + `CSB_SKIP_TWO : pc_o + `CSB_SKIP_ONE;
            next_wait = next_two_word_i ? `CSB_WAIT_SKIP_TWO : `CSB_WAIT_SKIP_ONE;
        end else if (next_take) begin
            next_pc = br_target;
            next_wait = `CSB_WAIT_BRANCH;
        end else begin
            next_pc = pc_o + `CSB_PC_STEP;
            next_wait = 2'h0;
        end
    end

    // sequencing: pc moves only on the last cycle of the instruction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= csb_pkg::ST_READY;
            wait_cnt <= 2'h0;
            pc_target <= `CSB_PC_RST;
            pc_o <= `CSB_PC_RST;
            ready_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            case (state)
                csb_pkg::ST_READY: begin
                    done_o <= 1'b0;
                    if (accept) begin
                        if (next_wait == 2'h0) begin
                            pc_o <= next_pc;
                            done_o <= 1'b1;
                        end else begin
                            pc_target <= next_pc;
                            wait_cnt <= next_wait;
                            ready_o <= 1'b0;
                            state <= csb_pkg::ST_WAIT;
                        end
                    end
                end
                csb_pkg::ST_WAIT: begin
                    wait_cnt <= wait_cnt - 2'h1;
                    if (wait_cnt == 2'h1) begin
                        pc_o <= pc_target;
                        done_o <= 1'b1;
                        ready_o <= 1'b1;
                        state <= csb_pkg::ST_READY;
                    end
                end
                default: begin
                    state <= csb_pkg::ST_READY;
                    ready_o <= 1'b1;
                    done_o <= 1'b0;
                end
            endcase
        end
    end

    // flags: compare wins over an outside write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= `CSB_FLAGS_RST;
        end else if (accept && op_i == csb_pkg::OP_COMPARE_IMMEDIATE) begin
            flags_o[`CSB_FLAG_Z] <= cmp_bus.res.z;
            flags_o[`CSB_FLAG_N] <= cmp_bus.res.n;
            flags_o[`CSB_FLAG_V] <= cmp_bus.res.v;
            flags_o[`CSB_FLAG_C] <= cmp_bus.res.c;
            flags_o[`CSB_FLAG_H] <= cmp_bus.res.h;
        end else if (flag_wr_i) begin
            flags_o <= flag_data_i;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic acc_br;
    logic acc_skip;
    logic [`CSB_PC_W-1:0] exp_skip;
    assign acc_br = accept && is_branch;
    assign acc_skip = accept && next_skip;
    assign exp_skip = next_two_word_i ? pc_o + `CSB_SKIP_TWO : pc_o + `CSB_SKIP_ONE;

    sequence s_wait_one;
        !ready_o ##1 ready_o;
    endsequence

    sequence s_wait_two;
        !ready_o [*2] ##1 ready_o;
    endsequence

    a_branch_fail_one: assert property (acc_br && !next_take |=> ready_o && done_o
        && pc_o == $past(pc_o) + `CSB_PC_STEP) else $error("failed branch not one cycle");
    a_branch_taken_pc: assert property (acc_br && next_take |=> s_wait_one ##0
        pc_o == $past(br_target, 2)) else $error("taken branch target wrong");
    a_carry_clear_cond: assert property (accept
        && op_i == csb_pkg::OP_BRANCH_CARRY_CLEAR
        |=> ready_o == $past(flags_o[`CSB_FLAG_C]))
        else $error("carry branch condition wrong");
    a_signed_ge_cond: assert property (accept && op_i == csb_pkg::OP_BRANCH_SIGNED_GE
        && (flags_o[`CSB_FLAG_N] != flags_o[`CSB_FLAG_V]) |=> done_o
        && pc_o == $past(pc_o) + `CSB_PC_STEP) else $error("signed ge taken wrongly");
    a_signed_lt_cond: assert property (accept && op_i == csb_pkg::OP_BRANCH_SIGNED_LT
        && (flags_o[`CSB_FLAG_N] != flags_o[`CSB_FLAG_V]) |=> !ready_o)
        else $error("signed lt not taken");
    a_skip_one_word: assert property (acc_skip && !next_two_word_i |=> s_wait_one ##0
        pc_o == $past(exp_skip, 2)) else $error("one word skip wrong");
    a_skip_two_word: assert property (acc_skip && next_two_word_i |=> s_wait_two ##0
        pc_o == $past(exp_skip, 3)) else $error("two word skip wrong");
    a_skip_eq_cond: assert property (accept && op_i == csb_pkg::OP_COMPARE_SKIP_EQUAL
        && reg_d_i != reg_r_i |=> ready_o && pc_o == $past(pc_o) + `CSB_PC_STEP)
        else $error("unequal compare skipped");
    a_reg_bit_skip: assert property (accept && op_i == csb_pkg::OP_SKIP_REG_BIT_CLEAR
        |=> ready_o == $past(reg_r_i[bit_sel_i])) else $error("register bit skip wrong");
    a_io_bit_skip: assert property (accept && (op_i == csb_pkg::OP_SKIP_IO_BIT_SET
        || op_i == csb_pkg::OP_SKIP_IO_BIT_CLEAR) |=> ready_o != ($past(io_val_i[bit_sel_i])
        == ($past(op_i) == csb_pkg::OP_SKIP_IO_BIT_SET))) else $error("io bit skip wrong");
    a_flag_set_cond: assert property (acc_br && (op_i == csb_pkg::OP_BRANCH_FLAG_SET
        || op_i == csb_pkg::OP_BRANCH_FLAG_CLEAR) |=> ready_o != ($past(flags_o[bit_sel_i])
        == ($past(op_i) == csb_pkg::OP_BRANCH_FLAG_SET)))
        else $error("flag branch condition wrong");
    a_cmp_imm_flags: assert property (accept && op_i == csb_pkg::OP_COMPARE_IMMEDIATE
        |=> ready_o && flags_o[`CSB_FLAG_Z] == ($past(reg_d_i) == $past(imm_i))
        && flags_o[`CSB_FLAG_C] == ($past(reg_d_i) < $past(imm_i)))
        else $error("compare immediate flags wrong");
    a_flags_kept: assert property ((accept && op_i != csb_pkg::OP_COMPARE_IMMEDIATE
        || !ready_o) && !flag_wr_i |=> $stable(flags_o)) else $error("flags changed");
endmodule // csb_unit

// ### tb/csb_fetch_model.sv
`timescale 1ns/10ps
`include "csb_cfg.svh"

module csb_fetch_model (
    // clock and handshake
    input wire logic clk_i,
    input wire logic ready_i,
    // decoded instruction
    output logic instr_valid_o,
    output csb_pkg::csb_op_t op_o,
    output logic [`CSB_DATA_W-1:0] reg_d_o,
    output logic [`CSB_DATA_W-1:0] reg_r_o,
    output logic [`CSB_DATA_W-1:0] imm_o,
    output logic [`CSB_DATA_W-1:0] io_val_o,
    output logic [`CSB_BIT_W-1:0] bit_sel_o,
    output logic [`CSB_OFS_W-1:0] offset_o,
    output logic next_two_word_o
);
    initial begin
        instr_valid_o = 1'b0;
        op_o = csb_pkg::OP_OTHER;
        {reg_d_o, reg_r_o, imm_o, io_val_o, bit_sel_o, offset_o, next_two_word_o} = '0;
    end

    // held until the edge that sees ready high; released operand fields are inverted, op_o is kept
    task automatic issue(input csb_pkg::csb_op_t op, input logic [7:0] d, r, imm, io,
        input logic [2:0] b, input logic [6:0] k, input logic two);
        @(posedge clk_i);
        instr_valid_o <= 1'b1;
        op_o <= op;
        {reg_d_o, reg_r_o, imm_o, io_val_o} <= {d, r, imm, io};
        {bit_sel_o, offset_o, next_two_word_o} <= {b, k, two};
        do @(posedge clk_i); while (ready_i !== 1'b1);
        instr_valid_o <= 1'b0;
        {reg_d_o, reg_r_o, imm_o, io_val_o} <= ~{d, r, imm, io};
        {bit_sel_o, offset_o, next_two_word_o} <= ~{b, k, two};
    endtask
endmodule // csb_fetch_model

// ### tb/tb_compare_skip_branch_unit.sv
`timescale 1ns/10ps
`include "csb_cfg.svh"

module tb_compare_skip_branch_unit;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic flag_wr_i = 1'b0;
    logic [7:0] flag_data_i = 8'h00;
    logic instr_valid_i, next_two_word_i, ready_o, done_o;
    csb_pkg::csb_op_t op_i;
    logic [7:0] reg_d_i, reg_r_i, imm_i, io_val_i, flags_o, model_flags;
    logic [2:0] bit_sel_i;
    logic [6:0] offset_i;
    logic [15:0] pc_o, model_pc;
    int bad_count = 0;
    int total_checks = 0;
    int cycle_count = 0;

    csb_unit csb_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .op_i(op_i), .reg_d_i(reg_d_i), .reg_r_i(reg_r_i), .imm_i(imm_i),
        .bit_sel_i(bit_sel_i), .io_val_i(io_val_i), .offset_i(offset_i),
        .next_two_word_i(next_two_word_i), .flag_wr_i(flag_wr_i), .flag_data_i(flag_data_i),
        .ready_o(ready_o), .done_o(done_o), .pc_o(pc_o), .flags_o(flags_o));
    csb_fetch_model csb_fetch_model_inst (.clk_i(clk_i), .ready_i(ready_o),
        .instr_valid_o(instr_valid_i), .op_o(op_i), .reg_d_o(reg_d_i), .reg_r_o(reg_r_i),
        .imm_o(imm_i), .io_val_o(io_val_i), .bit_sel_o(bit_sel_i), .offset_o(offset_i),
        .next_two_word_o(next_two_word_i));

    initial forever #2.5 clk_i = ~clk_i;

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, well above the roughly 80 cycles the tests need
    always @(posedge clk_i) begin
        cycle_count++;
        if (cycle_count == 5000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] cmp_flags(input logic [7:0] f, d, i);
        logic [7:0] res;
        res = d - i;
        f[`CSB_FLAG_Z] = (res == 8'h00);
        f[`CSB_FLAG_N] = res[7];
        f[`CSB_FLAG_C] = (d < i);
        f[`CSB_FLAG_V] = (d[7] != i[7]) && (res[7] != d[7]);
        f[`CSB_FLAG_H] = (d[3:0] < i[3:0]);
        return f;
    endfunction

    task automatic set_flags(input logic [7:0] v);
        @(posedge clk_i);
        flag_wr_i <= 1'b1;
        flag_data_i <= v;
        @(posedge clk_i);
        flag_wr_i <= 1'b0;
        flag_data_i <= ~v;
        #1 model_flags = v;
        check("flag write", flags_o, model_flags);
    endtask

    // one instruction: cost, new pc and flags judged against the bench model
    task automatic exec(input csb_pkg::csb_op_t op, input logic [31:0] ops,
        input logic [2:0] b, input logic [6:0] k, input logic two, taken);
        int n;
        int exp_n;
        logic br;
        logic [7:0] d, r, imm, io;
        {d, r, imm, io} = ops;
        br = (op >= csb_pkg::OP_BRANCH_FLAG_SET);
        exp_n = !taken ? 1 : (br ? 2 : (two ? 3 : 2));
        if (!taken)
            model_pc = model_pc + 16'h0001;
        else if (br)
            model_pc = model_pc + {{9{k[6]}}, k} + 16'h0001;
        else
            model_pc = model_pc + (two ? 16'h0003 : 16'h0002);
        if (op == csb_pkg::OP_COMPARE_IMMEDIATE)
            model_flags = cmp_flags(model_flags, d, imm);
        csb_fetch_model_inst.issue(op, d, r, imm, io, b, k, two);
        // a one-cycle done already stands just after the taking edge
        n = 1;
        #1;
        while (done_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("cycles", 16'(n), 16'(exp_n));
        check("pc", pc_o, model_pc);
        check("flags", flags_o, model_flags);
    endtask

    task automatic t_compare();
        set_flags(8'h10);
        exec(csb_pkg::OP_COMPARE_IMMEDIATE, 32'h10002000, 3'h0, 7'h00, 1'b0, 1'b0);
        exec(csb_pkg::OP_COMPARE_IMMEDIATE, 32'h80000100, 3'h0, 7'h00, 1'b0, 1'b0);
        exec(csb_pkg::OP_COMPARE_IMMEDIATE, 32'h3c003c00, 3'h0, 7'h00, 1'b0, 1'b0);
        exec(csb_pkg::OP_COMPARE_IMMEDIATE, 32'h08000100, 3'h0, 7'h00, 1'b0, 1'b0);
        exec(csb_pkg::OP_OTHER, 32'h00000000, 3'h0, 7'h00, 1'b0, 1'b0);
        $display("test compare done");
    endtask

    task automatic t_skips();
        exec(csb_pkg::OP_COMPARE_SKIP_EQUAL, 32'h5a5a0000, 3'h0, 7'h00, 1'b0, 1'b1);
        exec(csb_pkg::OP_COMPARE_SKIP_EQUAL, 32'h5a5a0000, 3'h0, 7'h00, 1'b1, 1'b1);
        exec(csb_pkg::OP_COMPARE_SKIP_EQUAL, 32'h5a5b0000, 3'h0, 7'h00, 1'b1, 1'b0);
        exec(csb_pkg::OP_SKIP_REG_BIT_CLEAR, 32'h00fb0000, 3'h2, 7'h00, 1'b0, 1'b1);
        exec(csb_pkg::OP_SKIP_REG_BIT_CLEAR, 32'h00fb0000, 3'h3, 7'h00, 1'b0, 1'b0);
        exec(csb_pkg::OP_SKIP_IO_BIT_SET, 32'h00000080, 3'h7, 7'h00, 1'b0, 1'b1);
        exec(csb_pkg::OP_SKIP_IO_BIT_SET, 32'h00000080, 3'h6, 7'h00, 1'b0, 1'b0);
        exec(csb_pkg::OP_SKIP_IO_BIT_CLEAR, 32'h00000080, 3'h6, 7'h00, 1'b1, 1'b1);
        exec(csb_pkg::OP_SKIP_IO_BIT_CLEAR, 32'h00000080, 3'h7, 7'h00, 1'b1, 1'b0);
        $display("test skips done");
    endtask

    task automatic t_branches();
        set_flags(8'h01);
        exec(csb_pkg::OP_BRANCH_FLAG_SET, 32'h00000000, 3'h0, 7'h05, 1'b0, 1'b1);
        exec(csb_pkg::OP_BRANCH_FLAG_CLEAR, 32'h00000000, 3'h0, 7'h05, 1'b0, 1'b0);
        exec(csb_pkg::OP_BRANCH_CARRY_CLEAR, 32'h00000000, 3'h0, 7'h05, 1'b0, 1'b0);
        set_flags(8'h00);
        exec(csb_pkg::OP_BRANCH_CARRY_CLEAR, 32'h00000000, 3'h0, 7'h7e, 1'b0, 1'b1);
        exec(csb_pkg::OP_BRANCH_FLAG_CLEAR, 32'h00000000, 3'h1, 7'h40, 1'b0, 1'b1);
        exec(csb_pkg::OP_BRANCH_FLAG_SET, 32'h00000000, 3'h1, 7'h40, 1'b0, 1'b0);
        set_flags(8'h04);
        exec(csb_pkg::OP_BRANCH_SIGNED_LT, 32'h00000000, 3'h0, 7'h3f, 1'b0, 1'b1);
        exec(csb_pkg::OP_BRANCH_SIGNED_GE, 32'h00000000, 3'h0, 7'h3f, 1'b0, 1'b0);
        set_flags(8'h0c);
        exec(csb_pkg::OP_BRANCH_SIGNED_GE, 32'h00000000, 3'h0, 7'h7f, 1'b0, 1'b1);
        exec(csb_pkg::OP_BRANCH_SIGNED_LT, 32'h00000000, 3'h0, 7'h7f, 1'b0, 1'b0);
        $display("test branches done");
    endtask

    initial begin
        model_pc = 16'h0000;
        model_flags = 8'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check("reset pc", pc_o, model_pc);
        check("reset flags", flags_o, model_flags);
        check("reset ready", {15'h0000, ready_o}, 16'h0001);
        check("reset done", {15'h0000, done_o}, 16'h0000);
        t_compare();
        t_skips();
        t_branches();
        summarize();
    end
endmodule // tb_compare_skip_branch_unit
